/* reset_watchdog_regs.vh */
`ifndef RESET_WATCHDOG_REGS_VH
`define RESET_WATCHDOG_REGS_VH
// clock rate in kHz (200 MHz)
`define MCLK_KHZ            200000
// watchdog period in ms (1.6 s)
`define WATCHDOG_PERIOD_MS  1600
// reset stretch timeout in ms (typ 200, bounds 130..270)
`define STRETCH_TIMEOUT_MS  200
// supply trip to reset delay, longest, in ns
`define TRIP_DELAY_MAX_NS   5000
// glitch reject width in ns
`define GLITCH_REJECT_NS    100
`define WATCHDOG_CYCLES     (`WATCHDOG_PERIOD_MS * `MCLK_KHZ)
`define STRETCH_CYCLES      (`STRETCH_TIMEOUT_MS * `MCLK_KHZ)
// strictly wider than the reject width: round up, then one more
`define GLITCH_CYCLES       ((`GLITCH_REJECT_NS * 200 + 999) / 1000 + 1)
`define TRIP_DELAY_CYCLES   ((`TRIP_DELAY_MAX_NS * 200) / 1000)
`endif

/* pin_sync.v */
`timescale 1ns/10ps
// three-stage synchroniser; output changes once stages two and three agree
module pin_sync (
  input  wire mclk,
  input  wire arst_n,
  input  wire pin,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end
endmodule // pin_sync

/* supervisory_reset_watchdog.v */
`timescale 1ns/10ps
`include "reset_watchdog_regs.vh"
// How it works
// - With no kick edge for longer than the watchdog period the watchdog times out.
// - A watchdog timeout asserts both reset pins and starts a reset like any other source.
// - Every rising or falling kick edge clears the watchdog counter.
// - While reset is asserted the watchdog counter is held at zero.
// - Resets are held while the supply is low, then for the stretch timeout after it recovers.
// - At the end of the timeout both open-drain pins are released to their pull resistors.
// - A low supply report asserts both resets during power-down or brownout.
// - Resets assert within 5 us of the supply dropping below the trip level.
// - A rising edge on the active-high pin starts a full timeout.
// - A falling edge on the active-low pin starts a full timeout.
// - A forced reset on either pin is taken over and held on both pins until timeout.
// - Pulses on the reset pins no wider than 100 ns never start a reset.
module supervisory_reset_watchdog #(
  parameter WATCHDOG_CYCLES = `WATCHDOG_CYCLES,
  parameter STRETCH_CYCLES  = `STRETCH_CYCLES,
  parameter GLITCH_CYCLES   = `GLITCH_CYCLES,
  parameter CNT_W           = 32,
  parameter GL_W            = 6
) (
  input  wire mclk,
  input  wire arst_n,
  input  wire supply_low,
  input  wire watchdog_kick_input,
  input  wire rst_hi_in,
  output wire rst_hi_out,
  output wire rst_hi_oe,
  input  wire rst_lo_n_in,
  output wire rst_lo_n_out,
  output wire rst_lo_n_oe,
  output wire reset_active
);
  localparam ST_HOLD    = 1'b0;
  localparam ST_RUN     = 1'b1;

  wire        low_s;
  wire        kick_s;
  wire        hi_s;
  wire        lo_s;
  reg         kick_d_r;
  reg         hi_f_r;
  reg         lo_f_r;
  reg         hi_fd_r;
  reg         lo_fd_r;
  reg  [GL_W-1:0] hi_gl_r;
  reg  [GL_W-1:0] lo_gl_r;
  reg         state_r;
  reg         state_nxt;
  reg  [CNT_W-1:0] stretch_r;
  reg  [CNT_W-1:0] stretch_nxt;
  reg  [CNT_W-1:0] wd_r;
  reg  [CNT_W-1:0] wd_nxt;
  wire        wd_expire;
  wire        manual;
  wire        kick_edge;
  wire        hi_rise;
  wire        lo_rise;
  wire        hold_done;
  wire        run_trip;
  reg  [GL_W-1:0] hi_gl_nxt;
  reg  [GL_W-1:0] lo_gl_nxt;
  reg         hi_f_nxt;
  reg         lo_f_nxt;

  // supply comparator: 4 flops = 20 ns, well inside 5 us
  pin_sync u_low (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin     (supply_low),
    .level_r (low_s)
  );
  pin_sync u_kick (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin     (watchdog_kick_input),
    .level_r (kick_s)
  );
  pin_sync u_hi (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin     (rst_hi_in),
    .level_r (hi_s)
  );
  // inverted so both pins look active high from here on
  pin_sync u_lo (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin     (~rst_lo_n_in),
    .level_r (lo_s)
  );

  // a new level must stand GLITCH_CYCLES cycles in a row
  // one cycle past the reject width, so a 100 ns pulse never gets through
  always @* begin
    hi_gl_nxt = hi_gl_r;
    hi_f_nxt  = hi_f_r;
    if (hi_s == hi_f_r) begin
      hi_gl_nxt = {GL_W{1'b0}};
    end else if (hi_gl_r == GLITCH_CYCLES[GL_W-1:0] - 1'b1) begin
      hi_gl_nxt = {GL_W{1'b0}};
      hi_f_nxt  = hi_s;
    end else begin
      hi_gl_nxt = hi_gl_r + 1'b1;
    end
  end

  always @* begin
    lo_gl_nxt = lo_gl_r;
    lo_f_nxt  = lo_f_r;
    if (lo_s == lo_f_r) begin
      lo_gl_nxt = {GL_W{1'b0}};
    end else if (lo_gl_r == GLITCH_CYCLES[GL_W-1:0] - 1'b1) begin
      lo_gl_nxt = {GL_W{1'b0}};
      lo_f_nxt  = lo_s;
    end else begin
      lo_gl_nxt = lo_gl_r + 1'b1;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hi_gl_r <= {GL_W{1'b0}};
      hi_f_r  <= 1'b0;
      hi_fd_r <= 1'b0;
    end else begin
      hi_gl_r <= hi_gl_nxt;
      hi_f_r  <= hi_f_nxt;
      hi_fd_r <= hi_f_r;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lo_gl_r <= {GL_W{1'b0}};
      lo_f_r  <= 1'b0;
      lo_fd_r <= 1'b0;
    end else begin
      lo_gl_r <= lo_gl_nxt;
      lo_f_r  <= lo_f_nxt;
      lo_fd_r <= lo_f_r;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      kick_d_r <= 1'b0;
    end else begin
      kick_d_r <= kick_s;
    end
  end

  // edges only: our own drive reads back asserted, so pins are ignored while holding
  assign hi_rise   = hi_f_r & ~hi_fd_r;
  assign lo_rise   = lo_f_r & ~lo_fd_r;
  assign manual    = hi_rise | lo_rise;
  assign kick_edge = kick_s ^ kick_d_r;
  assign hold_done = (stretch_r >= STRETCH_CYCLES[CNT_W-1:0] - 1'b1);
  assign run_trip  = low_s | manual | wd_expire;

  assign wd_expire = (wd_r >= WATCHDOG_CYCLES[CNT_W-1:0] - 1'b1);

  always @* begin
    state_nxt   = state_r;
    stretch_nxt = stretch_r;
    wd_nxt      = wd_r;
    case (state_r)
      ST_HOLD: begin
        wd_nxt = {CNT_W{1'b0}};
        if (low_s)
          stretch_nxt = {CNT_W{1'b0}};
        else if (hold_done)
          state_nxt = ST_RUN;
        else
          stretch_nxt = stretch_r + 1'b1;
      end
      ST_RUN: begin
        if (run_trip) begin
          state_nxt   = ST_HOLD;
          stretch_nxt = {CNT_W{1'b0}};
          wd_nxt      = {CNT_W{1'b0}};
        end else if (kick_edge)
          wd_nxt = {CNT_W{1'b0}};
        else
          wd_nxt = wd_r + 1'b1;
      end
      default: begin
        state_nxt   = ST_HOLD;
        stretch_nxt = {CNT_W{1'b0}};
        wd_nxt      = {CNT_W{1'b0}};
      end
    endcase
  end

  // reset comes up holding, so outputs are asserted from the first instant
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stretch_r <= {CNT_W{1'b0}};
    end else begin
      stretch_r <= stretch_nxt;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wd_r <= {CNT_W{1'b0}};
    end else begin
      wd_r <= wd_nxt;
    end
  end

  // open drain: drive only the asserted level, pulls give inactive
  assign reset_active = (state_r == ST_HOLD);
  assign rst_hi_out   = 1'b1;
  assign rst_hi_oe    = reset_active;
  assign rst_lo_n_out = 1'b0;
  assign rst_lo_n_oe  = reset_active;
endmodule // supervisory_reset_watchdog

/* reset_sva.sv */
`timescale 1ns/10ps
module reset_sva #(parameter WATCHDOG_CYCLES = 500, STRETCH_CYCLES = 200) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic supply_low,
  input wire logic watchdog_kick_input,
  input wire logic rst_hi_in,
  input wire logic rst_hi_out,
  input wire logic rst_hi_oe,
  input wire logic rst_lo_n_in,
  input wire logic rst_lo_n_out,
  input wire logic rst_lo_n_oe,
  input wire logic reset_active
);
  int idle_r, held_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // raw kick edges lead the synchroniser, hence the slack below
  always @(posedge mclk or negedge arst_n)
    if (!arst_n) {idle_r, held_r} <= 64'h0;
    else begin
      idle_r <= rst_hi_oe || $changed(watchdog_kick_input) ? 0 : idle_r + 1;
      held_r <= supply_low || !rst_hi_oe ? 0 : held_r + 1;
    end
  pins_paired_a: assert property (rst_hi_oe == rst_lo_n_oe) else $error("pins differ");
  flag_match_a: assert property (reset_active == rst_hi_oe) else $error("flag differs");
  drive_level_a: assert property (rst_hi_out && !rst_lo_n_out) else $error("drive level");
  supply_trip_a: assert property (supply_low |-> ##[0:1000] rst_hi_oe) else $error("late trip");
  low_hold_a: assert property (supply_low && rst_hi_oe |=> rst_hi_oe) else $error("early release");
  clean_release_a: assert property ($fell(rst_hi_oe) |-> !supply_low && !$past(supply_low))
    else $error("low supply");
  stretch_len_a: assert property ($fell(rst_hi_oe) |-> $past(held_r) inside {[STRETCH_CYCLES-2:STRETCH_CYCLES+8]})
    else $error("stretch length");
  kick_starve_a: assert property (idle_r <= WATCHDOG_CYCLES + 8) else $error("watchdog late");
endmodule // reset_sva

/* mcu_model.sv */
`timescale 1ns/10ps
module mcu_model (
  input  wire  mclk,
  input  wire  kick_en,
  input  wire  f_hi,
  input  wire  f_lo,
  input  wire  rst_hi_out,
  input  wire  rst_hi_oe,
  input  wire  rst_lo_n_out,
  input  wire  rst_lo_n_oe,
  output logic watchdog_kick_input = 0,
  output wire  rst_hi_in,
  output wire  rst_lo_n_in
);
  int n = 0;
  always @(negedge mclk) begin
    n = kick_en ? n + 1 : 0;
    if (n % 100 == 99) watchdog_kick_input <= ~watchdog_kick_input;
  end
  // released pin falls back to its pull: low for the high pin, high for the low pin
  assign rst_hi_in = (rst_hi_oe & rst_hi_out) | f_hi; // pull-down
  assign rst_lo_n_in = !((rst_lo_n_oe & !rst_lo_n_out) | f_lo); // pull-up
endmodule // mcu_model

/* testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("CHECK FAILED %0t reset", $time); end end
bind supervisory_reset_watchdog reset_sva #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES), .STRETCH_CYCLES(STRETCH_CYCLES)) u_sva (.*);
module testbench;
  logic mclk = 0, arst_n, supply_low, kick_en, f_hi, f_lo;
  wire watchdog_kick_input, rst_hi_in, rst_lo_n_in, rst_hi_out, rst_hi_oe, rst_lo_n_out, rst_lo_n_oe, reset_active;
  logic q[$] = {1'b0};
  int fail_count, n_compared, cyc;
  integer seed = 32'haa37eb02;
  supervisory_reset_watchdog #(.WATCHDOG_CYCLES(500), .STRETCH_CYCLES(200))
    u_supervisory_reset_watchdog (.*);
  mcu_model u_mcu_model (.*);
  task automatic w(int n);
    repeat (n) @(negedge mclk);
  endtask
  task close_out;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 8000) begin
    fail_count++;
    close_out;
  end
  always @(reset_active) if (arst_n) begin
    `CHK(reset_active, q.size() ? q.pop_front() : 1'bx)
  end
  initial begin
    {arst_n, supply_low, kick_en, f_hi, f_lo} = 0;
    w(8);
    arst_n = 1;
    w(250);
    kick_en = 1;
    // two short pin glitches first, then real sources, then a starved watchdog
    for (int i = 0; i < 6; i++) begin
      if (i > 1) q = {q, 1'b1, 1'b0};
      case (i)
        0, 3: f_lo = 1;
        1, 4: f_hi = 1;
        2: supply_low = 1;
        default: kick_en = 0;
      endcase
      w(i < 2 ? 20 : 24 + {$random(seed)} % 30);
      {supply_low, f_hi, f_lo} = 0;
      w(i < 5 ? 300 : 850);
      kick_en = 1;
    end
    w(400);
    `CHK(q.size(), 0)
    close_out;
  end
endmodule // testbench
